//--- logic/ddsfo_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Reset loads hold and both words with 1 kHz.
// - Words are 32 bits; hold reads as hex.
// - Send-both loads A from first, B from second.
// - Load both chips, then one shared strobe.
// - Legacy a and b commands act like send-both.
// - Mirror commands load both chips from one word.
// - Mirror commands leave channel words untouched.
// - Dollar means hex, hash decimal; radix remembered.
// - Enter or space ends entry; prompt shows errors.
// - Numeric entry changes only the holding word and radix.
// - Change-and-output stores word and updates chip.
// - Hex hold copied unchanged; decimal hold converted.
// - Hold and radix kept until next entry.
// - Set-only commands store word, outputs untouched.
// - Direct output drives chip from hold, words untouched.
// - Decimal direct: product, then temp, then transmit.
// - Hex direct: copy hold to temp, transmit from hold.
// - Other chip loads from its own word.
// - Send commands leave holding word unchanged.
// - Conversion multiplies into a 64-bit product.
// - Load is four frequency bytes plus control byte.
module ddsfo_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             dds_sclk,
   output logic             dds_data_a,
   output logic             dds_data_b,
   output logic             shared_update_strobe
);
   import ddsfo_pkg::*;

   // ************************************************************
   // State.
   // ************************************************************
   ddsfo_state_t state_q;
   ddsfo_op_t    op_q;
   ddsfo_entry_t entry_q;
   logic [31:0]  hold_q, afreq_q, bfreq_q, temp_q, acc_q;
   logic [31:0]  ascale_q, bscale_q;
   logic [63:0]  prod_q;
   logic         hex_q, zpend_q, prompt_q;
   logic [7:0]   errs_q;
   logic [39:0]  sh_a_q, sh_b_q;
   logic [5:0]   bits_q;
   logic [3:0]   div_q;
   logic         tick, sclk_q;

   // ************************************************************
   // APB decode and character parsing.
   // ************************************************************
   logic         wr_en, rd_en, char_wr, busy;
   logic [7:0]   ch;
   logic [3:0]   dig;
   logic         dig_ok, is_term, cmd_go;
   ddsfo_op_t    cmd_op;
   logic [31:0]  conv_in, conv_scale, load_v, word_a, word_b;
   logic [63:0]  prod_d;

   // Mapped addresses; anything else answers with an error.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= ADDR_PROMPT) && (a[1:0] == 2'b00);
   endfunction

   // The slave is always ready; every access ends in its access cycle.
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign busy    = (state_q != S_IDLE);
   assign char_wr = wr_en && (paddr == ADDR_CHAR) && !busy;
   assign ch      = pwdata[7:0];
   assign is_term = (ch == CH_CR) || (ch == CH_SP);
   assign pslverr = psel && penable && (!mapped(paddr) ||
                    (pwrite && (paddr == ADDR_CHAR) && busy));

   // Digit value of the character under the current radix.
   always_comb begin
      dig    = 4'h0;
      dig_ok = 1'b0;
      if (ch >= 8'h30 && ch <= 8'h39) begin
         dig    = ch[3:0];
         dig_ok = 1'b1;
      end else if (entry_q == E_HEX && ((ch >= 8'h61 && ch <= 8'h66) ||
                   (ch >= 8'h41 && ch <= 8'h46))) begin
         dig    = 4'(ch[3:0] + 4'h9);
         dig_ok = 1'b1;
      end
   end

   // Command letter decode; a pending z resolves on the next character.
   always_comb begin
      cmd_go = 1'b0;
      cmd_op = OP_SEND;
      if (char_wr && entry_q == E_NONE) begin
         if (zpend_q) begin
            cmd_go = 1'b1;
            if (ch == CH_LA) begin
               cmd_op = OP_MIRA;
            end else if (ch == CH_LB) begin
               cmd_op = OP_MIRB;
            end
         end else begin
            cmd_go = 1'b1;
            unique case (ch)
               CH_LA, CH_LB: cmd_op = OP_SEND;
               CH_UA:        cmd_op = OP_CHGA;
               CH_UB:        cmd_op = OP_CHGB;
               CH_LY:        cmd_op = OP_SETA;
               CH_UY:        cmd_op = OP_SETB;
               CH_LH:        cmd_op = OP_DIRA;
               CH_UH:        cmd_op = OP_DIRB;
               default:      cmd_go = 1'b0;
            endcase
         end
      end
   end

   // Numeric entry: prefix, digits, terminator; a bad digit abandons it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         entry_q <= E_NONE;
         acc_q   <= 32'h0;
         zpend_q <= 1'b0;
      end else if (char_wr) begin
         if (entry_q != E_NONE) begin
            if (is_term) begin
               entry_q <= E_NONE;
            end else if (!dig_ok) begin
               entry_q <= E_NONE;
            end else if (entry_q == E_HEX) begin
               acc_q <= {acc_q[27:0], dig};
            end else begin
               acc_q <= (acc_q << 3) + (acc_q << 1) + {28'h0, dig};
            end
         end else if (zpend_q) begin
            zpend_q <= 1'b0;
         end else if (ch == CH_HEX) begin
            entry_q <= E_HEX;
            acc_q   <= 32'h0;
         end else if (ch == CH_DEC) begin
            entry_q <= E_DEC;
            acc_q   <= 32'h0;
         end else if (ch == CH_LZ) begin
            zpend_q <= 1'b1;
         end
      end
   end

   // The holding word and radix change only when an entry completes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= DEF_LOAD;
         hex_q  <= 1'b1;
      end else if (char_wr && entry_q != E_NONE && is_term) begin
         hold_q <= acc_q;
         hex_q  <= (entry_q == E_HEX);
      end
   end

   // Error count and prompt flag; a new prompt wins over a read clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         errs_q   <= 8'h00;
         prompt_q <= 1'b0;
      end else begin
         if (char_wr && ((entry_q != E_NONE && !is_term && !dig_ok) ||
             (entry_q == E_NONE && !zpend_q && !cmd_go && ch != CH_HEX &&
              ch != CH_DEC && ch != CH_LZ && !is_term))) begin
            errs_q <= 8'(errs_q + 8'h01);
         end else if (wr_en && paddr == ADDR_ERRCLR) begin
            errs_q <= 8'h00;
         end
         if (char_wr && entry_q != E_NONE && is_term) begin
            prompt_q <= 1'b1;
         end else if (rd_en && paddr == ADDR_PROMPT) begin
            prompt_q <= 1'b0;
         end
      end
   end

   // Scaling words are software writable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ascale_q <= DEF_SCALE;
         bscale_q <= DEF_SCALE;
      end else if (wr_en && paddr == ADDR_ASCALE) begin
         ascale_q <= pwdata;
      end else if (wr_en && paddr == ADDR_BSCALE) begin
         bscale_q <= pwdata;
      end
   end

   // ************************************************************
   // Conversion and word selection.
   // ************************************************************
   // Product of frequency and scale; load taken from bits 55:24.
   assign conv_in    = hold_q;
   assign conv_scale = (op_q == OP_CHGB || op_q == OP_SETB ||
                        op_q == OP_DIRB) ? bscale_q : ascale_q;
   assign prod_d     = 64'(conv_in) * 64'(conv_scale);
   assign load_v     = hex_q ? hold_q : prod_q[LOAD_MSB:LOAD_LSB];

   // Words heading for each chip for the current operation.
   always_comb begin
      word_a = afreq_q;
      word_b = bfreq_q;
      unique case (op_q)
         OP_MIRA: word_b = afreq_q;
         OP_MIRB: word_a = bfreq_q;
         OP_CHGA: word_a = load_v;
         OP_CHGB: word_b = load_v;
         OP_DIRA: word_a = load_v;
         OP_DIRB: word_b = load_v;
         default: word_a = afreq_q;
      endcase
   end

   // ************************************************************
   // Command sequencer.
   // ************************************************************
   // Send and mirror steps skip conversion; hold use steps pass through it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
         op_q    <= OP_SEND;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (cmd_go) begin
                  op_q    <= cmd_op;
                  state_q <= (cmd_op == OP_SEND || cmd_op == OP_MIRA ||
                              cmd_op == OP_MIRB) ? S_LOAD : S_CONV;
               end
            end
            S_CONV: state_q <= S_LOAD;
            S_LOAD: begin
               state_q <= (op_q == OP_SETA || op_q == OP_SETB) ?
                          S_IDLE : S_SHIFT;
            end
            S_SHIFT: begin
               if (tick && sclk_q && bits_q == SHIFT_BITS - 6'd1) begin
                  state_q <= S_STROBE;
               end
            end
            S_STROBE: begin
               if (tick) begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Product word for decimal entries.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prod_q <= 64'h0;
      end else if (state_q == S_CONV && !hex_q) begin
         prod_q <= prod_d;
      end
   end

   // Channel words change only on change or set commands.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         afreq_q <= DEF_LOAD;
         bfreq_q <= DEF_LOAD;
      end else if (state_q == S_LOAD) begin
         if (op_q == OP_CHGA || op_q == OP_SETA) begin
            afreq_q <= load_v;
         end
         if (op_q == OP_CHGB || op_q == OP_SETB) begin
            bfreq_q <= load_v;
         end
      end
   end

   // Temporary word holds the direct output value.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_q <= 32'h0;
      end else if (state_q == S_LOAD && (op_q == OP_DIRA || op_q == OP_DIRB)) begin
         temp_q <= load_v;
      end
   end

   // ************************************************************
   // Serial link to the two chips.
   // ************************************************************
   // Bit-rate enable from a divider of pclk.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 4'h0;
      end else if (state_q == S_SHIFT || state_q == S_STROBE) begin
         div_q <= (div_q == SCLK_DIV - 4'd1) ? 4'h0 : 4'(div_q + 4'd1);
      end else begin
         div_q <= 4'h0;
      end
   end
   assign tick = (div_q == SCLK_DIV - 4'd1);

   // Both chips shift together, least significant bit first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_a_q <= 40'h0;
         sh_b_q <= 40'h0;
         bits_q <= 6'd0;
         sclk_q <= 1'b0;
      end else if (state_q == S_LOAD) begin
         sh_a_q <= {CTRL_BYTE, word_a};
         sh_b_q <= {CTRL_BYTE, word_b};
         bits_q <= 6'd0;
         sclk_q <= 1'b0;
      end else if (state_q == S_SHIFT && tick) begin
         sclk_q <= !sclk_q;
         if (sclk_q) begin
            sh_a_q <= {1'b0, sh_a_q[39:1]};
            sh_b_q <= {1'b0, sh_b_q[39:1]};
            bits_q <= 6'(bits_q + 6'd1);
         end
      end
   end

   // Link pins come straight from flip-flops or the state register.
   assign dds_sclk             = sclk_q;
   assign dds_data_a           = sh_a_q[0];
   assign dds_data_b           = sh_b_q[0];
   assign shared_update_strobe = (state_q == S_STROBE);

   // ************************************************************
   // Read data.
   // ************************************************************
   always_comb begin
      prdata = 32'h0;
      if (rd_en) begin
         unique case (paddr)
            ADDR_STATUS: begin
               prdata[ST_BUSY]            = busy;
               prdata[ST_HEX]             = hex_q;
               prdata[ST_ENTRY]           = (entry_q != E_NONE);
               prdata[ST_ERRS +: 8]       = errs_q;
            end
            ADDR_HOLD:   prdata = hold_q;
            ADDR_AFREQ:  prdata = afreq_q;
            ADDR_BFREQ:  prdata = bfreq_q;
            ADDR_TEMP:   prdata = temp_q;
            ADDR_PRODLO: prdata = prod_q[31:0];
            ADDR_PRODHI: prdata = prod_q[63:32];
            ADDR_ASCALE: prdata = ascale_q;
            ADDR_BSCALE: prdata = bscale_q;
            ADDR_PROMPT: begin
               prdata[PR_VALID] = prompt_q;
               prdata[3:0]      = errs_q[3:0];
            end
            default:     prdata = 32'h0;
         endcase
      end
   end

endmodule // ddsfo_top

//--- logic/ddsfo_pkg.sv
package ddsfo_pkg;

   // ************************************************************
   // Register map, byte addresses on the APB.
   // ************************************************************
   localparam logic [7:0] ADDR_CHAR   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_HOLD   = 8'h08;
   localparam logic [7:0] ADDR_AFREQ  = 8'h0c;
   localparam logic [7:0] ADDR_BFREQ  = 8'h10;
   localparam logic [7:0] ADDR_TEMP   = 8'h14;
   localparam logic [7:0] ADDR_PRODLO = 8'h18;
   localparam logic [7:0] ADDR_PRODHI = 8'h1c;
   localparam logic [7:0] ADDR_ASCALE = 8'h20;
   localparam logic [7:0] ADDR_BSCALE = 8'h24;
   localparam logic [7:0] ADDR_ERRCLR = 8'h28;
   localparam logic [7:0] ADDR_PROMPT = 8'h2c;

   // ************************************************************
   // Reset values and field positions.
   // ************************************************************
   localparam logic [31:0] DEF_LOAD   = 32'h0000_8637;
   localparam logic [31:0] DEF_SCALE  = 32'h225c_17d0;
   localparam logic [7:0]  CTRL_BYTE  = 8'h00;
   localparam int          LOAD_LSB   = 24;
   localparam int          LOAD_MSB   = 55;
   localparam logic [5:0]  SHIFT_BITS = 6'd40;
   localparam logic [3:0]  SCLK_DIV   = 4'd4;
   localparam int          ST_BUSY    = 0;
   localparam int          ST_HEX     = 1;
   localparam int          ST_ENTRY   = 2;
   localparam int          ST_ERRS    = 8;
   localparam int          PR_VALID   = 8;

   // ************************************************************
   // Characters understood by the interpreter.
   // ************************************************************
   localparam logic [7:0] CH_HEX = 8'h24;
   localparam logic [7:0] CH_DEC = 8'h23;
   localparam logic [7:0] CH_CR  = 8'h0d;
   localparam logic [7:0] CH_SP  = 8'h20;
   localparam logic [7:0] CH_LA  = 8'h61;
   localparam logic [7:0] CH_LB  = 8'h62;
   localparam logic [7:0] CH_LZ  = 8'h7a;
   localparam logic [7:0] CH_UA  = 8'h41;
   localparam logic [7:0] CH_UB  = 8'h42;
   localparam logic [7:0] CH_LY  = 8'h79;
   localparam logic [7:0] CH_UY  = 8'h59;
   localparam logic [7:0] CH_LH  = 8'h68;
   localparam logic [7:0] CH_UH  = 8'h48;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_CONV   = 3'b001,
      S_LOAD   = 3'b010,
      S_SHIFT  = 3'b011,
      S_STROBE = 3'b100
   } ddsfo_state_t;

   typedef enum logic [3:0] {
      OP_SEND = 4'h0,
      OP_MIRA = 4'h1,
      OP_MIRB = 4'h2,
      OP_CHGA = 4'h3,
      OP_CHGB = 4'h4,
      OP_SETA = 4'h5,
      OP_SETB = 4'h6,
      OP_DIRA = 4'h7,
      OP_DIRB = 4'h8
   } ddsfo_op_t;

   typedef enum logic [1:0] {
      E_NONE = 2'b00,
      E_HEX  = 2'b01,
      E_DEC  = 2'b10
   } ddsfo_entry_t;

endpackage : ddsfo_pkg

//--- bench/ddsfo_chip_model.sv
`timescale 1ns/1ps
// ************************************************************
// Serial synthesizer chip seen from its load pins.
// ************************************************************
module ddsfo_chip_model (
   input  wire logic        presetn,
   input  wire logic        sclk,
   input  wire logic        din,
   input  wire logic        strobe,
   output logic      [31:0] freq_q,
   output logic      [7:0]  ctrl_q,
   output logic      [15:0] loads_q
);
   logic [39:0] shift_q;

   // Bits enter least significant first on each rising serial clock.
   always_ff @(posedge sclk or negedge presetn) begin
      if (!presetn) begin
         shift_q <= 40'h0;
      end else begin
         shift_q <= {din, shift_q[39:1]};
      end
   end

   // The shared strobe moves the shifted word to the chip output.
   always_ff @(posedge strobe or negedge presetn) begin
      if (!presetn) begin
         freq_q  <= 32'h0;
         ctrl_q  <= 8'h00;
         loads_q <= 16'h0;
      end else begin
         freq_q  <= shift_q[31:0];
         ctrl_q  <= shift_q[39:32];
         loads_q <= loads_q + 16'h1;
      end
   end
endmodule // ddsfo_chip_model

//--- bench/ddsfo_assertions.sv
`timescale 1ns/1ps
module ddsfo_checker
   import ddsfo_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        dds_sclk,
   input wire logic        dds_data_a,
   input wire logic        dds_data_b,
   input wire logic        shared_update_strobe
);
   logic [7:0] edges_q;
   logic       sclk_q;

   // Counts rising serial clock edges since the last strobe.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edges_q <= 8'h00;
         sclk_q  <= 1'b0;
      end else begin
         sclk_q <= dds_sclk;
         if (shared_update_strobe) begin
            edges_q <= 8'h00;
         end else if (dds_sclk && !sclk_q) begin
            edges_q <= edges_q + 8'h01;
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ************************************************************
   // Link framing and bus answers.
   // ************************************************************
   strobe_width_a: assert property ($rose(shared_update_strobe) |->
      shared_update_strobe[*4] ##1 !shared_update_strobe) else $error("strobe width wrong");
   frame_bits_a: assert property ($rose(shared_update_strobe) |-> edges_q == 8'd40)
      else $error("frame bit count wrong");
   strobe_quiet_a: assert property (shared_update_strobe |-> !dds_sclk)
      else $error("serial clock high during strobe");
   sclk_high_a: assert property ($rose(dds_sclk) |-> dds_sclk[*4] ##1 !dds_sclk)
      else $error("serial clock high phase wrong");
   sclk_low_a: assert property ($fell(dds_sclk) |-> !dds_sclk[*4])
      else $error("serial clock low phase short");
   data_setup_a: assert property (($changed(dds_data_a) || $changed(dds_data_b))
      |-> !dds_sclk) else $error("data moved while clock high");
   read_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read access");
   unmapped_a: assert property (psel && penable && paddr > ADDR_PROMPT |-> pslverr)
      else $error("unmapped access not flagged");
endmodule // ddsfo_checker

bind ddsfo_top ddsfo_checker ddsfo_checker_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .dds_sclk(dds_sclk),
   .dds_data_a(dds_data_a), .dds_data_b(dds_data_b),
   .shared_update_strobe(shared_update_strobe));

//--- bench/ddsfo_test.sv
`timescale 1ns/1ps
module ddsfo_test;
   import ddsfo_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        sclk, da, db, stb;
   logic [7:0]  paddr, ca, cb;
   logic [15:0] na, nb;
   logic [31:0] pwdata, prdata, rd, fa, fb, c500, c2k;
   int          fails, check_count;
   string       sends [3] = '{"zx", "a", "b"};

   ddsfo_top ddsfo_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dds_sclk(sclk),
      .dds_data_a(da), .dds_data_b(db), .shared_update_strobe(stb));
   ddsfo_chip_model ddsfo_chip_model_a_inst (.presetn(presetn), .sclk(sclk), .din(da),
      .strobe(stb), .freq_q(fa), .ctrl_q(ca), .loads_q(na));
   ddsfo_chip_model ddsfo_chip_model_b_inst (.presetn(presetn), .sclk(sclk), .din(db),
      .strobe(stb), .freq_q(fb), .ctrl_q(cb), .loads_q(nb));

   // Free-running bus clock.
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ************************************************************
   // Bus and comparison helpers.
   // ************************************************************
   task stop_test;
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // One APB transfer; data and error are taken at the ready edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task reg_is(input logic [7:0] a, input string n, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask

   // A command that never finishes counts as a mismatch.
   task wait_idle;
      for (int i = 0; i < 500; i++) begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         if (rd[ST_BUSY] === 1'b0) break;
      end
      if (rd[ST_BUSY] !== 1'b0) begin
         fails++;
         $display("[FAIL] busy expected 0 seen %b", rd[ST_BUSY]);
      end
   endtask

   // Sends characters one by one, each once the interpreter is idle.
   task send(input string s);
      foreach (s[i]) begin
         wait_idle();
         apb(1'b1, ADDR_CHAR, {24'h0, s[i]});
      end
      wait_idle();
   endtask

   task out(input logic [31:0] ea, input logic [31:0] eb);
      chk("chip_a", ea, fa);
      chk("chip_b", eb, fb);
   endtask

   // Main sequence.
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      fails = 0;
      check_count = 0;
      // Load values for 500 Hz and 2000 Hz at the default scale.
      c500 = 32'h0000_431b;
      c2k = 32'h0001_0c6f;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      reg_is(ADDR_HOLD, "hold", DEF_LOAD);
      reg_is(ADDR_AFREQ, "afreq", DEF_LOAD);
      reg_is(ADDR_BFREQ, "bfreq", DEF_LOAD);
      reg_is(ADDR_ASCALE, "ascale", DEF_SCALE);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      send("$12345678 y");
      reg_is(ADDR_AFREQ, "afreq", 32'h1234_5678);
      send("#2000 Y");
      reg_is(ADDR_BFREQ, "bfreq", c2k);
      chk("loads", 32'h0, {16'h0, na});
      reg_is(ADDR_HOLD, "hold", 32'h0000_07d0);
      reg_is(ADDR_STATUS, "status", 32'h0);
      foreach (sends[i]) begin
         send(sends[i]);
         out(32'h1234_5678, c2k);
         chk("loads", i + 1, {16'h0, nb});
      end
      reg_is(ADDR_HOLD, "hold", 32'h0000_07d0);
      chk("ctrl", {24'h0, CTRL_BYTE}, {24'h0, ca});
      chk("ctrl_b", {24'h0, CTRL_BYTE}, {24'h0, cb});
      send("z");
      apb(1'b1, ADDR_CHAR, 32'h78);
      apb(1'b1, ADDR_CHAR, {24'h0, CH_LA});
      chk("busy_err", 32'h1, {31'h0, err});
      wait_idle();
      chk("loads", 32'h4, {16'h0, na});
      send("za");
      out(32'h1234_5678, 32'h1234_5678);
      send("zb");
      out(c2k, c2k);
      reg_is(ADDR_AFREQ, "afreq", 32'h1234_5678);
      send("zx");
      out(32'h1234_5678, c2k);
      send("$431b ");
      reg_is(ADDR_AFREQ, "afreq", 32'h1234_5678);
      reg_is(ADDR_TEMP, "temp", 32'h0);
      chk("loads", 32'h7, {16'h0, na});
      reg_is(ADDR_STATUS, "status", 32'h2);
      reg_is(ADDR_PROMPT, "prompt", 32'h100);
      send("B");
      reg_is(ADDR_BFREQ, "bfreq", 32'h431b);
      out(32'h1234_5678, 32'h431b);
      send("#500 A");
      reg_is(ADDR_AFREQ, "afreq", c500);
      out(c500, 32'h431b);
      send("#2000 h");
      out(c2k, 32'h431b);
      reg_is(ADDR_TEMP, "temp", c2k);
      reg_is(ADDR_PRODHI, "prodhi", 32'h0000_010c);
      reg_is(ADDR_PRODLO, "prodlo", 32'h6f7a_0900);
      reg_is(ADDR_AFREQ, "afreq", c500);
      send("$abc H");
      out(c500, 32'h0abc);
      reg_is(ADDR_TEMP, "temp", 32'h0abc);
      reg_is(ADDR_BFREQ, "bfreq", 32'h431b);
      apb(1'b1, ADDR_ASCALE, 32'h0100_0000);
      send("#1234 A");
      reg_is(ADDR_AFREQ, "afreq", 32'd1234);
      apb(1'b1, ADDR_ASCALE, DEF_SCALE);
      send("q#7 ");
      reg_is(ADDR_PROMPT, "prompt", 32'h101);
      apb(1'b1, ADDR_ERRCLR, 32'h0);
      reg_is(ADDR_STATUS, "status", 32'h0);
      stop_test();
   end

   // Cuts a hung run short.
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      stop_test();
   end
endmodule // ddsfo_test
